// ===== design/rofs_pkg.sv
package rofs_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 1; // prescaler step, in ms
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned NCH = 8;
  // duration limit in seconds, above it a parameter error shows
  localparam logic [15:0] DUR_MAX_S = 16'h1c20;
  // register byte offsets
  localparam logic [7:0] A_SUBST_SEL = 8'h00;
  localparam logic [7:0] A_USER_VAL = 8'h04;
  localparam logic [7:0] A_FINAL_VAL = 8'h08;
  localparam logic [7:0] A_WDOG_MS = 8'h0c;
  localparam logic [7:0] A_UPD_MS = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_PARAM_ERR = 8'h18;
  localparam logic [7:0] A_IRQ_STAT = 8'h1c;
  localparam logic [7:0] A_IRQ_CLR = 8'h20;
  localparam logic [7:0] A_IRQ_EN = 8'h24;
  localparam logic [7:0] A_DUR0 = 8'h40; // eight words, one per channel
  // reset values
  localparam logic [7:0] SUBST_SEL_RST = 8'h00; // 0 = user value
  localparam logic [7:0] USER_VAL_RST = 8'h00;
  localparam logic [7:0] FINAL_VAL_RST = 8'h00; // off
  localparam logic [15:0] DUR_RST = 16'h0000;
  localparam logic [15:0] WDOG_MS_RST = 16'h0064;
  localparam logic [15:0] UPD_MS_RST = 16'h000a;
  // status byte codes
  localparam logic [7:0] STAT_GOOD = 8'h80;
  localparam logic [7:0] STAT_BAD = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // channel states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SUBST = 3'b010,
    ST_FINAL = 3'b100
  } rofs_st_e;
  // one cyclic input byte per channel
  typedef struct packed {
    logic [5:0] rsvd;
    logic fault;
    logic value;
  } rofs_in_byte_s;
  // one cyclic output byte per channel
  typedef struct packed {
    logic [6:0] rsvd;
    logic value;
  } rofs_out_byte_s;
endpackage : rofs_pkg

// ===== design/rofs_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module rofs_top #(
  parameter int unsigned CYC_PER_MS = rofs_pkg::CYC_PER_MS,
  parameter int unsigned MS_PER_S = rofs_pkg::MS_PER_S
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // cyclic output image from the gateway
  input wire logic cyc_out_valid,
  input wire logic cyc_out_good,
  input wire rofs_pkg::rofs_out_byte_s [7:0] cyc_out_data,
  // cyclic input image and status bytes to the gateway
  output rofs_pkg::rofs_in_byte_s [7:0] cyc_in_q,
  output logic cyc_in_valid_q,
  output logic [7:0][7:0] iops_q,
  output logic [7:0][7:0] iocs_q,
  // field side pins
  input wire logic [7:0] line_fault_pin,
  input wire logic module_fail_pin,
  input wire logic module_absent_pin,
  output logic [7:0] relay_q,
  // interrupt
  output logic irq_q
);
  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // duration word index, or 8 when the address is not a duration word
  function automatic logic [3:0] dur_idx(input logic [7:0] a);
    if (a[7:5] == rofs_pkg::A_DUR0[7:5] && a[1:0] == 2'b00) begin
      return {1'b0, a[4:2]};
    end
    return 4'h8;
  endfunction : dur_idx

  // software registers
  logic [7:0] subst_sel_q; // 1 = hold last value
  logic [7:0] user_val_q;
  logic [7:0] final_val_q;
  logic [15:0] wdog_ms_q;
  logic [15:0] upd_ms_q;
  logic [7:0][15:0] dur_q;
  logic [15:0] irq_en_q;
  logic [15:0] irq_stat_q;
  logic [7:0] perr_q;
  // bus handshake state
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_hs, w_hs, ar_hs, do_wr;
  logic [31:0] rd_d;
  logic rd_err;
  // link and time base
  logic link_fault_q, lf_set, enter;
  logic [7:0] cmd_q;
  logic [15:0] ms_cnt_q, wd_cnt_q, upd_cnt_q;
  logic [15:0] s_cnt_q;
  logic ms_tick, sec_tick;
  // synchronised pins
  logic [9:0] pin_m_q, pin_s_q;
  logic [7:0] lf_s;
  // per-channel results
  logic [7:0] relay_d, in_fault, ev_final;
  logic [7:0] relay_fin_q; // final state seen last cycle, for the edge detect

  assign aw_hs = s_awvalid & s_awready;
  assign w_hs = s_wvalid & s_wready;
  assign ar_hs = s_arvalid & s_arready;
  assign do_wr = aw_have_q & w_have_q & ~s_bvalid;
  assign lf_s = pin_s_q[7:0];

  // two-flop synchroniser for the field pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_q <= 10'h000;
      pin_s_q <= 10'h000;
    end else begin
      pin_m_q <= {module_absent_pin, module_fail_pin, line_fault_pin};
      pin_s_q <= pin_m_q;
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= rofs_pkg::RESP_OKAY;
    end else begin
      s_awready <= ~aw_hs & ~aw_have_q & ~s_bvalid & ~do_wr;
      s_wready <= ~w_hs & ~w_have_q & ~s_bvalid & ~do_wr;
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= rofs_pkg::RESP_OKAY;
        if (awaddr_q > rofs_pkg::A_IRQ_EN && dur_idx(awaddr_q) == 4'h8) begin
          s_bresp <= rofs_pkg::RESP_SLVERR; // unmapped
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; read-only words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      subst_sel_q <= rofs_pkg::SUBST_SEL_RST;
      user_val_q <= rofs_pkg::USER_VAL_RST;
      final_val_q <= rofs_pkg::FINAL_VAL_RST;
      wdog_ms_q <= rofs_pkg::WDOG_MS_RST;
      upd_ms_q <= rofs_pkg::UPD_MS_RST;
      irq_en_q <= 16'h0000;
      for (int c = 0; c < rofs_pkg::NCH; c++) begin
        dur_q[c] <= rofs_pkg::DUR_RST;
      end
    end else if (do_wr) begin
      unique case (awaddr_q)
        rofs_pkg::A_SUBST_SEL: subst_sel_q <= 8'(merge({24'h0, subst_sel_q}, wdata_q, wstrb_q));
        rofs_pkg::A_USER_VAL: user_val_q <= 8'(merge({24'h0, user_val_q}, wdata_q, wstrb_q));
        rofs_pkg::A_FINAL_VAL: final_val_q <= 8'(merge({24'h0, final_val_q}, wdata_q, wstrb_q));
        rofs_pkg::A_WDOG_MS: wdog_ms_q <= 16'(merge({16'h0, wdog_ms_q}, wdata_q, wstrb_q));
        rofs_pkg::A_UPD_MS: upd_ms_q <= 16'(merge({16'h0, upd_ms_q}, wdata_q, wstrb_q));
        rofs_pkg::A_IRQ_EN: irq_en_q <= 16'(merge({16'h0, irq_en_q}, wdata_q, wstrb_q));
        default: begin
          if (dur_idx(awaddr_q) != 4'h8) begin
            dur_q[3'(dur_idx(awaddr_q))] <=
              16'(merge({16'h0, dur_q[3'(dur_idx(awaddr_q))]}, wdata_q, wstrb_q));
          end
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    unique case (s_araddr)
      rofs_pkg::A_SUBST_SEL: rd_d = {24'h0, subst_sel_q};
      rofs_pkg::A_USER_VAL: rd_d = {24'h0, user_val_q};
      rofs_pkg::A_FINAL_VAL: rd_d = {24'h0, final_val_q};
      rofs_pkg::A_WDOG_MS: rd_d = {16'h0, wdog_ms_q};
      rofs_pkg::A_UPD_MS: rd_d = {16'h0, upd_ms_q};
      rofs_pkg::A_STATUS: rd_d = {7'h0, link_fault_q, ev_final, in_fault, relay_q};
      rofs_pkg::A_PARAM_ERR: rd_d = {24'h0, perr_q};
      rofs_pkg::A_IRQ_STAT: rd_d = {16'h0, irq_stat_q};
      rofs_pkg::A_IRQ_CLR: rd_d = 32'h00000000; // write-only
      rofs_pkg::A_IRQ_EN: rd_d = {16'h0, irq_en_q};
      default: begin
        if (dur_idx(s_araddr) != 4'h8) begin
          rd_d = {16'h0, dur_q[3'(dur_idx(s_araddr))]};
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // read channel, one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= rofs_pkg::RESP_OKAY;
    end else begin
      s_arready <= ~ar_hs & ~s_rvalid;
      if (ar_hs) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_d;
        s_rresp <= rd_err ? rofs_pkg::RESP_SLVERR : rofs_pkg::RESP_OKAY;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // millisecond prescaler, free running
  assign ms_tick = (ms_cnt_q == 16'(CYC_PER_MS - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
    end
  end

  // seconds prescaler restarts at fault entry; the ms prescaler runs on, so the first second can fall short by under one ms
  assign sec_tick = ms_tick & (s_cnt_q == 16'(MS_PER_S - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || enter) begin
      s_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      s_cnt_q <= sec_tick ? 16'h0000 : s_cnt_q + 16'h0001;
    end
  end

  // link supervision: bad data or silence past the watchdog enters fault
  assign lf_set = (cyc_out_valid & ~cyc_out_good) |
                  (wdog_ms_q != 16'h0000 && wd_cnt_q >= wdog_ms_q);
  assign enter = lf_set & ~link_fault_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_fault_q <= 1'b0;
      wd_cnt_q <= 16'h0000;
      cmd_q <= 8'h00;
    end else if (cyc_out_valid && cyc_out_good) begin
      link_fault_q <= 1'b0;
      wd_cnt_q <= 16'h0000;
      for (int c = 0; c < rofs_pkg::NCH; c++) begin
        cmd_q[c] <= cyc_out_data[c].value;
      end
    end else begin
      link_fault_q <= link_fault_q | lf_set;
      if (ms_tick && wd_cnt_q != 16'hffff) begin
        wd_cnt_q <= wd_cnt_q + 16'h0001;
      end
    end
  end

  // per-channel fault state machines
  genvar i;
  generate
    for (i = 0; i < rofs_pkg::NCH; i++) begin : g_ch
      rofs_pkg::rofs_st_e st_q;
      logic [15:0] sec_q;
      logic sub_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          st_q <= rofs_pkg::ST_RUN;
          sec_q <= 16'h0000;
          sub_q <= 1'b0;
        end else begin
          unique case (st_q)
            rofs_pkg::ST_RUN: begin
              if (enter) begin
                st_q <= rofs_pkg::ST_SUBST;
                sec_q <= 16'h0000;
                sub_q <= subst_sel_q[i] ? cmd_q[i] : user_val_q[i];
              end
            end
            rofs_pkg::ST_SUBST: begin
              if (!link_fault_q) begin
                st_q <= rofs_pkg::ST_RUN;
              end else if (sec_tick) begin
                if (sec_q != 16'hffff) begin
                  sec_q <= sec_q + 16'h0001;
                end
                // zero duration never expires
                if (dur_q[i] != 16'h0000 && sec_q + 16'h0001 >= dur_q[i]) begin
                  st_q <= rofs_pkg::ST_FINAL;
                end
              end
            end
            rofs_pkg::ST_FINAL: begin
              if (!link_fault_q) begin
                st_q <= rofs_pkg::ST_RUN;
              end
            end
            default: st_q <= rofs_pkg::ST_RUN;
          endcase
        end
      end
      // contact drive per state
      assign relay_d[i] = (st_q == rofs_pkg::ST_RUN) ? cmd_q[i] :
                          (st_q == rofs_pkg::ST_SUBST) ? sub_q : final_val_q[i];
      assign in_fault[i] = (st_q != rofs_pkg::ST_RUN);
      assign ev_final[i] = (st_q == rofs_pkg::ST_FINAL);
    end
  endgenerate

  // relay outputs and parameter check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_q <= 8'h00;
      perr_q <= 8'h00;
    end else begin
      relay_q <= relay_d;
      for (int c = 0; c < rofs_pkg::NCH; c++) begin
        perr_q[c] <= (dur_q[c] > rofs_pkg::DUR_MAX_S);
      end
    end
  end

  // status bytes; line faults only spoil the consumer status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iops_q <= '0;
      iocs_q <= '0;
    end else begin
      for (int c = 0; c < rofs_pkg::NCH; c++) begin
        iops_q[c] <= (pin_s_q[8] | pin_s_q[9]) ? rofs_pkg::STAT_BAD
                                               : rofs_pkg::STAT_GOOD;
        iocs_q[c] <= (pin_s_q[8] | pin_s_q[9] | lf_s[c]) ? rofs_pkg::STAT_BAD
                                                         : rofs_pkg::STAT_GOOD;
      end
    end
  end

  // input image published every upd_ms milliseconds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_cnt_q <= 16'h0000;
      cyc_in_valid_q <= 1'b0;
      cyc_in_q <= '0;
    end else begin
      cyc_in_valid_q <= 1'b0;
      if (ms_tick) begin
        upd_cnt_q <= upd_cnt_q + 16'h0001;
        if (upd_cnt_q + 16'h0001 >= upd_ms_q) begin
          upd_cnt_q <= 16'h0000;
          cyc_in_valid_q <= 1'b1;
          for (int c = 0; c < rofs_pkg::NCH; c++) begin
            cyc_in_q[c] <= '{rsvd: 6'h00, fault: in_fault[c] | lf_s[c],
                             value: relay_q[c]};
          end
        end
      end
    end
  end

  // local interrupt only; nothing is raised as a bus alarm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~((do_wr && awaddr_q == rofs_pkg::A_IRQ_CLR) ?
                    wdata_q[15:0] : 16'h0000)) | {ev_final & ~relay_fin_q, {8{enter}}};
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // final-state edge detect for the interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_fin_q <= 8'h00;
    end else begin
      relay_fin_q <= ev_final;
    end
  end
endmodule : rofs_top

// ===== dv/rofs_checker.sv
`timescale 1ns/100ps
module rofs_checker #(
  parameter int unsigned CYC_PER_MS = rofs_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cyclic images
  input wire logic cyc_out_valid,
  input wire logic cyc_out_good,
  input wire rofs_pkg::rofs_out_byte_s [7:0] cyc_out_data,
  input wire rofs_pkg::rofs_in_byte_s [7:0] cyc_in_q,
  input wire logic cyc_in_valid_q,
  input wire logic [7:0][7:0] iops_q,
  input wire logic [7:0][7:0] iocs_q,
  // field side
  input wire logic [7:0] line_fault_pin,
  input wire logic module_fail_pin,
  input wire logic module_absent_pin,
  input wire logic [7:0] relay_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] cmd, rsvd, flt; // commands, reserved-bit or, fault bits
  logic bad_q; // invalid image seen, no good one since
  logic [7:0] age_q; // cycles since that invalid image
  int unsigned gap_q; // cycles since last update pulse
  // unpack the per-channel bytes
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      cmd[c] = cyc_out_data[c].value;
      rsvd[c] = |cyc_in_q[c].rsvd;
      flt[c] = cyc_in_q[c].fault;
    end
  end
  // age of an unanswered invalid image, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || (cyc_out_valid && cyc_out_good)) begin
      bad_q <= 1'b0;
      age_q <= 8'h00;
    end else if (cyc_out_valid) begin
      bad_q <= 1'b1;
      age_q <= 8'h00;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end
  // gap between update pulses
  always_ff @(posedge aclk) begin
    if (!aresetn || cyc_in_valid_q) begin
      gap_q <= 0;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  property p_iops_bad;
    module_fail_pin [*4] |=> iops_q == {8{rofs_pkg::STAT_BAD}};
  endproperty
  a_iops_bad: assert property (p_iops_bad) else $error("producer status not bad");
  property p_iops_line;
    (!module_fail_pin && !module_absent_pin) [*4] |=> iops_q == {8{rofs_pkg::STAT_GOOD}};
  endproperty
  a_iops_line: assert property (p_iops_line) else $error("producer status hit");
  property p_iocs_line;
    line_fault_pin[0] [*4] |=> iocs_q[0] == rofs_pkg::STAT_BAD;
  endproperty
  a_iocs_line: assert property (p_iocs_line) else $error("consumer status not bad");
  property p_iocs_good;
    (line_fault_pin == 8'h00 && !module_fail_pin && !module_absent_pin) [*4]
      |=> iocs_q == {8{rofs_pkg::STAT_GOOD}};
  endproperty
  a_iocs_good: assert property (p_iocs_good) else $error("consumer status not good");
  property p_in_rsvd;
    cyc_in_valid_q |-> rsvd == 8'h00;
  endproperty
  a_in_rsvd: assert property (p_in_rsvd) else $error("reserved input bits set");
  property p_relay;
    // one spare edge: leaving fault mode takes a cycle longer than running
    cyc_out_valid && cyc_out_good ##1 !cyc_out_valid |=> ##1 relay_q == $past(cmd, 3);
  endproperty
  a_relay: assert property (p_relay) else $error("relay ignores command");
  property p_fault_bit;
    cyc_in_valid_q && bad_q && age_q > 8'h04 |-> flt == 8'hff;
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit missing");
  property p_upd_gap;
    gap_q <= 10 * CYC_PER_MS + 4;
  endproperty
  a_upd_gap: assert property (p_upd_gap) else $error("input image late");
  property p_upd_pulse;
    cyc_in_valid_q |=> !cyc_in_valid_q;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
  c_bad: cover property (cyc_out_valid && !cyc_out_good);
  c_line: cover property (line_fault_pin[0] [*4]);
  c_fail: cover property (module_fail_pin [*4]);
endmodule : rofs_checker
bind rofs_top rofs_checker #(.CYC_PER_MS(CYC_PER_MS)) rofs_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .cyc_out_valid(cyc_out_valid),
  .cyc_out_good(cyc_out_good), .cyc_out_data(cyc_out_data), .cyc_in_q(cyc_in_q),
  .cyc_in_valid_q(cyc_in_valid_q), .iops_q(iops_q), .iocs_q(iocs_q),
  .line_fault_pin(line_fault_pin), .module_fail_pin(module_fail_pin),
  .module_absent_pin(module_absent_pin), .relay_q(relay_q));

// ===== dv/rofs_gw_model.sv
`timescale 1ns/100ps
module rofs_gw_model (
  // clock
  input wire logic aclk,
  // image towards the block
  output logic cyc_out_valid,
  output logic cyc_out_good,
  output rofs_pkg::rofs_out_byte_s [7:0] cyc_out_data,
  // image back from the block
  input wire rofs_pkg::rofs_in_byte_s [7:0] cyc_in_q,
  input wire logic cyc_in_valid_q,
  input wire logic [7:0][7:0] iops_q
);
  rofs_pkg::rofs_in_byte_s [7:0] last_in = '0; // last trusted input image
  int unsigned n_upd = 0; // update pulses seen
  int unsigned stale = 0; // cycles without fresh data
  logic stale_err = 1'b0; // supervision alarm, no fresh data
  initial begin
    cyc_out_valid = 1'b0;
    cyc_out_good = 1'b0;
    cyc_out_data = '0;
  end
  // watch the exchange; a bad producer status keeps the old image
  always @(posedge aclk) begin
    if (cyc_in_valid_q) begin
      stale <= 0;
      n_upd <= n_upd + 1;
      if (iops_q[0] === rofs_pkg::STAT_GOOD) last_in <= cyc_in_q;
    end else begin
      stale <= stale + 1;
    end
    stale_err <= stale > 1000;
  end
  // one image, one cycle; junk in reserved bits, data scrambled after
  task automatic send(input logic good, input logic [7:0] cmd, input logic [6:0] junk);
    @(posedge aclk);
    cyc_out_valid <= 1'b1;
    cyc_out_good <= good;
    for (int c = 0; c < 8; c++) cyc_out_data[c] <= {junk, cmd[c]};
    @(posedge aclk);
    cyc_out_valid <= 1'b0;
    cyc_out_data <= ~cyc_out_data;
  endtask : send
endmodule : rofs_gw_model

// ===== dv/relay_output_fault_state_channel_tb.sv
`timescale 1ns/100ps
module relay_output_fault_state_channel_tb;
  localparam int SEC = 12; // 4 cycles per ms, 3 ms per second
  // clock, reset, bus
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  // images and field pins
  logic cyc_out_valid, cyc_out_good, cyc_in_valid_q, irq_q;
  rofs_pkg::rofs_out_byte_s [7:0] cyc_out_data;
  rofs_pkg::rofs_in_byte_s [7:0] cyc_in_q;
  logic [7:0][7:0] iops_q, iocs_q;
  logic [7:0] line_fault_pin = 8'h00, relay_q;
  logic module_fail_pin = 1'b0, module_absent_pin = 1'b0;
  int fails = 0, n_compared = 0;
  always #25 aclk = ~aclk; // 20 MHz
  rofs_top #(.CYC_PER_MS(4), .MS_PER_S(3)) rofs_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .cyc_out_valid(cyc_out_valid), .cyc_out_good(cyc_out_good),
    .cyc_out_data(cyc_out_data), .cyc_in_q(cyc_in_q), .cyc_in_valid_q(cyc_in_valid_q),
    .iops_q(iops_q), .iocs_q(iocs_q), .line_fault_pin(line_fault_pin),
    .module_fail_pin(module_fail_pin), .module_absent_pin(module_absent_pin),
    .relay_q(relay_q), .irq_q(irq_q));
  rofs_gw_model rofs_gw_model_inst (.aclk(aclk), .cyc_out_valid(cyc_out_valid),
    .cyc_out_good(cyc_out_good), .cyc_out_data(cyc_out_data), .cyc_in_q(cyc_in_q),
    .cyc_in_valid_q(cyc_in_valid_q), .iops_q(iops_q));
  // n edges, then on to the settled falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc
  // register values, captured already
  task automatic chk_reg(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_reg
  // port values, taken by the caller mid-cycle where settled
  task automatic chk_pin(input logic [63:0] g, e, input string m);
    chk_reg(g[31:0], e[31:0], m);
    chk_reg(g[63:32], e[63:32], m);
  endtask : chk_pin
  // both write channels offered at once, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ra, rw;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      ra = aw && s_awready;
      rw = w && s_wready;
      @(posedge aclk);
      if (ra) s_awvalid <= 1'b0;
      if (rw) s_wvalid <= 1'b0;
      aw = aw && !ra;
      w = w && !rw;
    end
    do @(negedge aclk); while (!s_bvalid);
    chk_reg({30'h0, s_bresp}, {30'h0, rofs_pkg::RESP_OKAY}, "write resp");
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask : axi_wr
  // read one word and judge data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (!s_arready);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    @(posedge aclk);
    s_rready <= 1'b0;
    chk_reg(d, e, "read data");
    chk_reg({30'h0, r}, {30'h0, er}, "read resp");
  endtask : rd_chk
  // bounded wait for the next input image
  task automatic wait_upd;
    int unsigned n;
    n = rofs_gw_model_inst.n_upd;
    repeat (200) if (rofs_gw_model_inst.n_upd == n) @(posedge aclk);
    @(negedge aclk);
  endtask : wait_upd
  // expected input image from values and fault bits
  function automatic logic [63:0] img(input logic [7:0] v, f);
    logic [63:0] r;
    r = '0;
    for (int c = 0; c < 8; c++) r[c*8 +: 8] = {6'h00, f[c], v[c]};
    return r;
  endfunction : img
  task automatic t_reset_vals;
    rd_chk(rofs_pkg::A_SUBST_SEL, 32'h0, 2'b00);
    rd_chk(rofs_pkg::A_FINAL_VAL, 32'h0, 2'b00);
    rd_chk(rofs_pkg::A_DUR0, 32'h0, 2'b00);
    rd_chk(8'h30, 32'h0, rofs_pkg::RESP_SLVERR);
  endtask : t_reset_vals
  // limit itself is accepted, one above is flagged
  task automatic t_param;
    axi_wr(rofs_pkg::A_DUR0, {16'h0, rofs_pkg::DUR_MAX_S});
    rd_chk(rofs_pkg::A_PARAM_ERR, 32'h0, 2'b00);
    axi_wr(8'h44, {16'h0, rofs_pkg::DUR_MAX_S + 16'h0001});
    rd_chk(rofs_pkg::A_PARAM_ERR, 32'h2, 2'b00);
    axi_wr(8'h44, 32'h0);
    rd_chk(rofs_pkg::A_PARAM_ERR, 32'h0, 2'b00);
  endtask : t_param
  task automatic t_run;
    rofs_gw_model_inst.send(1'b1, 8'ha5, 7'h7f);
    cyc(2);
    chk_pin(relay_q, 64'ha5, "relay run");
    wait_upd();
    chk_pin(rofs_gw_model_inst.last_in, img(8'ha5, 8'h00), "image run");
  endtask : t_run
  // ch0-3 hold last, ch4-7 user value; ch7 never times out
  task automatic t_fault;
    axi_wr(rofs_pkg::A_SUBST_SEL, 32'h0f);
    axi_wr(rofs_pkg::A_USER_VAL, 32'h30);
    axi_wr(rofs_pkg::A_FINAL_VAL, 32'hd5);
    axi_wr(rofs_pkg::A_IRQ_EN, 32'h0);
    for (int c = 0; c < 8; c++) axi_wr(8'h40 + 8'(4 * c), (c == 7) ? 32'h0 : 32'h2);
    rofs_gw_model_inst.send(1'b0, 8'hff, 7'h00);
    cyc(SEC - 2);
    chk_pin(relay_q, 64'h35, "substitute");
    chk_pin(irq_q, 64'h0, "irq masked");
    cyc(3 * SEC);
    chk_pin(relay_q, 64'h55, "final");
    rd_chk(rofs_pkg::A_IRQ_STAT, 32'h7fff, 2'b00);
    axi_wr(rofs_pkg::A_IRQ_EN, 32'hffff);
    cyc(1);
    chk_pin(irq_q, 64'h1, "irq on");
    axi_wr(rofs_pkg::A_IRQ_CLR, 32'hffff);
    cyc(2);
    chk_pin(irq_q, 64'h0, "irq cleared");
    rd_chk(rofs_pkg::A_IRQ_STAT, 32'h0, 2'b00);
    wait_upd();
    chk_pin(rofs_gw_model_inst.last_in, img(8'h55, 8'hff), "image fault");
    rofs_gw_model_inst.send(1'b1, 8'h0f, 7'h55);
    cyc(2);
    chk_pin(relay_q, 64'h0f, "resume");
  endtask : t_fault
  task automatic t_status;
    @(posedge aclk);
    module_fail_pin <= 1'b1;
    cyc(6);
    chk_pin(iops_q, {8{rofs_pkg::STAT_BAD}}, "iops fail");
    chk_pin(iocs_q, {8{rofs_pkg::STAT_BAD}}, "iocs fail");
    @(posedge aclk);
    module_fail_pin <= 1'b0;
    module_absent_pin <= 1'b1;
    cyc(6);
    chk_pin(iops_q, {8{rofs_pkg::STAT_BAD}}, "iops absent");
    @(posedge aclk);
    module_absent_pin <= 1'b0;
    line_fault_pin <= 8'h01;
    cyc(6);
    chk_pin(iops_q, {8{rofs_pkg::STAT_GOOD}}, "iops line");
    chk_pin(iocs_q, {{7{rofs_pkg::STAT_GOOD}}, rofs_pkg::STAT_BAD}, "iocs line");
    chk_pin(rofs_gw_model_inst.stale_err, 64'h0, "exchange stale");
  endtask : t_status
  task automatic close_out;
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_reset_vals();
    t_param();
    t_run();
    t_fault();
    t_status();
    close_out();
  end
  // hang guard at 4000 cycles, far beyond the expected few hundred cycles
  initial begin
    #(4000 * 50);
    fails++;
    close_out();
  end
endmodule : relay_output_fault_state_channel_tb
